// ===== hw/usbirq_pkg.sv
// Package for the USB status interrupt logic: register map, bit layout,
// timing constants and the carrier structs.
// Assumes a 20 MHz system clock and a classic Wishbone register bus.
package usbirq_pkg;

	// Register word addresses (byte address, 32-bit aligned)
	localparam logic [3:0] USBIRQ_ADR_STATUS = 4'h0;
	localparam logic [3:0] USBIRQ_ADR_ENABLE = 4'h4;
	localparam logic [3:0] USBIRQ_ADR_ERRFLG = 4'h8;
	localparam logic [3:0] USBIRQ_ADR_ERREN = 4'hc;
	localparam logic [3:0] USBIRQ_ADR_DEVADR = 4'h0 + 4'h0 + 4'h0 + 4'h0;

	// Status and enable bit positions
	localparam int USBIRQ_B_RST = 0;
	localparam int USBIRQ_B_ERR = 1;
	localparam int USBIRQ_B_ACT = 2;
	localparam int USBIRQ_B_TRN = 3;
	localparam int USBIRQ_B_IDLE = 4;
	localparam int USBIRQ_B_STALL = 5;
	localparam int USBIRQ_B_SOF = 6;

	localparam logic [7:0] USBIRQ_STATUS_RST = 8'h00;
	localparam logic [7:0] USBIRQ_ERR_RST = 8'h00;
	// Writable status bits: all implemented except the error summary
	localparam logic [7:0] USBIRQ_STATUS_WMASK = 8'h7d;
	// Implemented error flag bits
	localparam logic [7:0] USBIRQ_ERR_MASK = 8'h9f;
	localparam logic [6:0] USBIRQ_ADDR_RST = 7'h00;
	localparam logic [31:0] USBIRQ_UNMAPPED = 32'h00000000;

	// Idle detection time
	localparam int USBIRQ_CLK_HZ = 20000000;
	localparam int USBIRQ_IDLE_MS = 3;
	localparam int USBIRQ_IDLE_CYC = USBIRQ_CLK_HZ / 1000 * USBIRQ_IDLE_MS;

	// Events from the serial interface engine, one-cycle pulses
	typedef struct packed {
		logic frame_start;
		logic stall_sent;
		logic trn_done;
		logic bus_reset;
		logic [7:0] err;
	} usbirq_evt_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} usbirq_wb_req_t;

endpackage

// ===== hw/usbirq_top.sv
// USB status interrupt flags, enables, error layer and request output.
// Assumes the engine pulses are synchronous to clk_sys_i; the bus lines
// come from pins and are synchronised here.
// Unmapped addresses answer with zero and ignore writes.
//
// Contract
// - All USB interrupt sources merge into one request line.
// - The request is the OR of status flags, each gated by its own enable.
// - Enables gate only the request; flags still set while disabled.
// - Enabled error-layer flags set the top-level error summary flag.
// - A hardware-set flag other than the error summary stays set until firmware writes zero to it.
// - Firmware may set writable status flags as if hardware had.
// - The idle flag sets after 3 ms of continuous bus idle.
// - The stall flag sets when a STALL handshake has been sent.
// - The transaction flag sets when a transaction completes.
// - Clearing the transaction flag advances the transaction status fifo.
// - The activity flag sets on activity on the D+ or D- lines.
// - Only one activity event per resume; rearm needs a new idle.
// - The error summary is read only and shows unmasked errors only.
// - A bus reset sets its flag and zeroes the device address register.
`timescale 1ns/100ps
`default_nettype none

module usbirq_top
	import usbirq_pkg::*;
#(
	parameter int IDLE_CYC = usbirq_pkg::USBIRQ_IDLE_CYC
) (
	input wire logic clk_sys_i, // System clock, 20 MHz
	input wire logic resetn_i, // Async reset, active low
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write
	input wire logic [3:0] wb_adr_i, // Wishbone byte address
	input wire logic [3:0] wb_sel_i, // Wishbone byte selects
	input wire logic [31:0] wb_dat_i, // Wishbone write data
	output logic [31:0] wb_dat_o, // Wishbone read data
	output logic wb_ack_o, // Wishbone acknowledge
	input wire logic [7:0] evt_err_i, // Error condition pulses
	input wire logic evt_frame_start_i, // Start-of-frame token received
	input wire logic evt_stall_sent_i, // STALL handshake sent
	input wire logic evt_trn_done_i, // Transaction completed
	input wire logic evt_bus_reset_i, // Valid bus reset seen
	input wire logic dp_i, // D+ line level (pin)
	input wire logic dm_i, // D- line level (pin)
	output logic fifo_advance_o, // Pulse: pop transaction status fifo
	output logic [6:0] device_address_o, // Device address register
	output logic usb_module_irq_request_o // Combined interrupt request
);
	import usbirq_pkg::*;

	typedef struct packed {
		logic line_prev;
		logic [31:0] idle_cnt;
		logic idle_seen;
		logic act_armed;
		logic [7:0] status;
		logic [7:0] enables;
		logic [7:0] err_flags;
		logic [7:0] err_enables;
		logic [6:0] dev_addr;
		logic ack;
		logic [31:0] rdata;
		logic advance;
	} usbirq_state_t;

	usbirq_state_t st_q;
	usbirq_state_t st_d;
	usbirq_evt_t evt;
	usbirq_wb_req_t req;

	logic dp_s;
	logic dm_s;
	logic line_idle;
	logic line_act;
	logic take;
	logic wr;
	logic [7:0] wv;
	logic hit_status;
	logic hit_enable;
	logic hit_errflg;
	logic hit_erren;
	logic [7:0] set_hw;
	logic [7:0] status_nx;
	logic [7:0] errf_nx;
	logic [31:0] rd_word;
	logic [31:0] idle_lim;
	assign idle_lim = 32'(IDLE_CYC);

	always_comb begin
		evt.frame_start = evt_frame_start_i;
		evt.stall_sent = evt_stall_sent_i;
		evt.trn_done = evt_trn_done_i;
		evt.bus_reset = evt_bus_reset_i;
		evt.err = evt_err_i;
		req.cyc = wb_cyc_i;
		req.stb = wb_stb_i;
		req.we = wb_we_i;
		req.adr = wb_adr_i;
		req.sel = wb_sel_i;
		req.dat = wb_dat_i;
	end

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	usbirq_sync2 u_dp_sync (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.pin_i(dp_i),
		.sync_o(dp_s)
	);

	usbirq_sync2 u_dm_sync (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.pin_i(dm_i),
		.sync_o(dm_s)
	);

	////////////////////////////////////////////////////////////////////////
	// Request decode and hardware set terms

	always_comb begin
		// Idle is the J state: D+ high, D- low
		line_idle = dp_s & ~dm_s;
		// Leaving idle is the activity edge; it repeats on each later J to K step
		line_act = st_q.line_prev & ~line_idle;
		// Bus slave: one-cycle ack, dropped the cycle after
		take = req.cyc & req.stb & ~st_q.ack;
		wr = take & req.we & req.sel[0];
		wv = req.dat[7:0];
		hit_status = req.adr == USBIRQ_ADR_STATUS;
		hit_enable = req.adr == USBIRQ_ADR_ENABLE;
		hit_errflg = req.adr == USBIRQ_ADR_ERRFLG;
		hit_erren = req.adr == USBIRQ_ADR_ERREN;
		set_hw = 8'h00;
		set_hw[USBIRQ_B_SOF] = evt.frame_start;
		set_hw[USBIRQ_B_STALL] = evt.stall_sent;
		set_hw[USBIRQ_B_TRN] = evt.trn_done;
		set_hw[USBIRQ_B_RST] = evt.bus_reset;
		set_hw[USBIRQ_B_IDLE] = st_q.idle_seen;
		// One activity event per resume, rearmed by idle
		set_hw[USBIRQ_B_ACT] = line_act & st_q.act_armed;
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky flag cells

	// Only the status layer lets firmware set a flag
	for (genvar gi = 0; gi < 8; gi++) begin : g_status_cell
		usbirq_sticky_bit u_cell (
			.q_i(st_q.status[gi]),
			.wr_i(wr & hit_status),
			.wv_i(wv[gi]),
			.set_i(set_hw[gi] & USBIRQ_STATUS_WMASK[gi]),
			.wset_i(USBIRQ_STATUS_WMASK[gi]),
			.d_o(status_nx[gi])
		);
	end

	// Error flags only clear from firmware, never set
	for (genvar gi = 0; gi < 8; gi++) begin : g_error_cell
		usbirq_sticky_bit u_cell (
			.q_i(st_q.err_flags[gi]),
			.wr_i(wr & hit_errflg),
			.wv_i(wv[gi]),
			.set_i(evt.err[gi] & USBIRQ_ERR_MASK[gi]),
			.wset_i(1'b0),
			.d_o(errf_nx[gi])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// Read data selection

	// Captured at the taking edge so it stands for the one ack cycle
	always_comb begin
		rd_word = USBIRQ_UNMAPPED;
		case (req.adr)
		USBIRQ_ADR_STATUS: begin
			rd_word = {24'h000000, st_q.status};
		end
		USBIRQ_ADR_ENABLE: begin
			rd_word = {24'h000000, st_q.enables};
		end
		USBIRQ_ADR_ERRFLG: begin
			rd_word = {24'h000000, st_q.err_flags};
		end
		USBIRQ_ADR_ERREN: begin
			rd_word = {24'h000000, st_q.err_enables};
		end
		default: begin
			rd_word = USBIRQ_UNMAPPED;
		end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		st_d = st_q;
		st_d.advance = 1'b0;

		// Level of the previous cycle, for the activity edge
		st_d.line_prev = line_idle;

		// Idle timer
		if (!line_idle) begin
			st_d.idle_cnt = 32'h00000000;
		end else if (st_q.idle_cnt < idle_lim) begin
			st_d.idle_cnt = st_q.idle_cnt + 32'h00000001;
		end
		st_d.idle_seen = 1'b0;
		if (line_idle && st_q.idle_cnt == idle_lim - 32'h00000001) begin
			st_d.idle_seen = 1'b1;
		end

		// Idle arms the activity event; the first activity disarms it
		if (st_q.idle_seen) begin
			st_d.act_armed = 1'b1;
		end else if (line_act) begin
			st_d.act_armed = 1'b0;
		end

		st_d.ack = take;

		// Error layer: sticky, write zero clears, set wins
		st_d.err_flags = errf_nx & USBIRQ_ERR_MASK;
		if (wr && hit_erren) begin
			st_d.err_enables = wv & USBIRQ_ERR_MASK;
		end
		if (wr && hit_enable) begin
			st_d.enables = wv & 8'h7f;
		end

		// Status: write of zero clears, write of one sets; hw set wins
		st_d.status = status_nx;
		if (wr && hit_status) begin
			if (st_q.status[USBIRQ_B_TRN] && !wv[USBIRQ_B_TRN]) begin
				st_d.advance = 1'b1;
			end
		end
		// Summary follows unmasked errors only, never written
		st_d.status[USBIRQ_B_ERR] =
			|(st_d.err_flags & st_d.err_enables);
		st_d.status[7] = 1'b0;

		// No bus write path: a status write must not move the address
		if (evt.bus_reset) begin
			st_d.dev_addr = USBIRQ_ADDR_RST;
		end

		st_d.rdata = USBIRQ_UNMAPPED;
		if (take) begin
			st_d.rdata = rd_word;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign wb_ack_o = st_q.ack;
	assign wb_dat_o = st_q.rdata;
	assign fifo_advance_o = st_q.advance;
	assign device_address_o = st_q.dev_addr;
	// Enables gate propagation only, not the flags
	assign usb_module_irq_request_o =
		|(st_q.status & st_q.enables);

endmodule // usbirq_top

////////////////////////////////////////////////////////////////////////////
// One sticky flag bit. A write of zero clears it; where firmware may set
// the bit, a write of one sets it. A hardware set in the same cycle wins,
// so an event is never lost to a clear that raced it.

module usbirq_sticky_bit (
	input wire logic q_i, // Present flag value
	input wire logic wr_i, // Write strobe for this register
	input wire logic wv_i, // Written bit value
	input wire logic set_i, // Hardware set term
	input wire logic wset_i, // Firmware may set this bit
	output logic d_o // Next flag value
);
	always_comb begin
		d_o = q_i;
		if (wr_i) begin
			d_o = wset_i ? wv_i : (q_i & wv_i);
		end
		if (set_i) begin
			d_o = 1'b1;
		end
	end

endmodule // usbirq_sticky_bit

////////////////////////////////////////////////////////////////////////////
// Two-flop synchroniser for a pin level

module usbirq_sync2 (
	input wire logic clk_sys_i, // System clock
	input wire logic resetn_i, // Async reset, active low
	input wire logic pin_i, // Asynchronous pin level
	output logic sync_o // Level after the second flop
);
	typedef struct packed {
		logic [1:0] stage;
	} usbirq_sync_t;

	usbirq_sync_t sy_q;
	usbirq_sync_t sy_d;

	// Only the second stage leaves, so the first may settle undisturbed
	always_comb begin
		sy_d.stage = {sy_q.stage[0], pin_i};
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sy_q <= '0;
		end else begin
			sy_q <= sy_d;
		end
	end

	assign sync_o = sy_q.stage[1];

endmodule // usbirq_sync2

`default_nettype wire

// ===== verif/usbirq_line_model.sv
// Bus line model: holds idle (J) or toggles the data lines.
// Bench drives act_i on the system clock.
`timescale 1ns/100ps
`default_nettype none
module usbirq_line_model (
	input wire logic clk_sys_i, // Clock
	input wire logic act_i, // Traffic on
	output logic dp_o, // D+
	output logic dm_o // D-
);
	logic tog_q = 1'b0;
	// Traffic flips J and K every cycle so idle never lasts
	always @(posedge clk_sys_i) tog_q <= act_i ? !tog_q : 1'b0;
	assign dp_o = !tog_q;
	assign dm_o = tog_q;
endmodule // usbirq_line_model
`default_nettype wire

// ===== verif/usbirq_properties.sv
// Checker for the bus, fifo pop and device address outputs.
// Bound to usbirq_top; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module usbirq_properties (
	input wire logic clk_sys_i, // Clock
	input wire logic resetn_i, // Reset
	input wire logic wb_cyc_i, // Cycle
	input wire logic wb_stb_i, // Strobe
	input wire logic wb_we_i, // Write
	input wire logic [3:0] wb_adr_i, // Address
	input wire logic [31:0] wb_dat_i, // Wdata
	input wire logic [31:0] wb_dat_o, // Rdata
	input wire logic wb_ack_o, // Ack
	input wire logic evt_bus_reset_i, // Bus reset
	input wire logic fifo_advance_o, // Pop
	input wire logic [6:0] device_address_o // Address
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
////////////////////////////////////////////////////////////////
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack1: assert property (p_ack1) else $error("ack long");
	property p_nreq; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
	a_nreq: assert property (p_nreq) else $error("stray ack");
	property p_rd;
		wb_ack_o && wb_adr_i == 4'h0 |-> wb_dat_o[31:7] == 25'h0;
	endproperty
	a_rd: assert property (p_rd) else $error("status top bits");
	property p_pop;
		fifo_advance_o |->
			$past(wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i &&
				wb_adr_i == 4'h0 && !wb_dat_i[3]);
	endproperty
	a_pop: assert property (p_pop) else $error("stray pop");
	property p_pop1; fifo_advance_o |=> !fifo_advance_o; endproperty
	a_pop1: assert property (p_pop1) else $error("pop long");
	property p_brst; evt_bus_reset_i |=> device_address_o == 7'h00; endproperty
	a_brst: assert property (p_brst) else $error("address kept");
	property p_adr;
		$changed(device_address_o) |-> $past(evt_bus_reset_i);
	endproperty
	a_adr: assert property (p_adr) else $error("address moved");
endmodule // usbirq_properties
bind usbirq_top usbirq_properties u_props (.clk_sys_i, .resetn_i,
	.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o,
	.wb_ack_o, .evt_bus_reset_i, .fifo_advance_o, .device_address_o);
`default_nettype wire

// ===== verif/usbirq_top_tb.sv
// Bench for usbirq_top: register rows, events, error layer, idle.
// Wishbone and engine pulses from here; D+/D- from the line model.
`timescale 1ns/100ps
`default_nettype none
module usbirq_top_tb;
	import usbirq_pkg::*;
	localparam int IC = 20;
	logic clk_sys_i = 1'b0;
	logic resetn_i = 1'b0;
	logic act = 1'b1;
	logic ack, dp, dm, irq, pop;
	logic [6:0] addr;
	logic [31:0] rdo, v;
	usbirq_wb_req_t req = '0;
	usbirq_evt_t evt = '0;
	int err_count = 0;
	int samples_checked = 0;
	int pops = 0;
	always @(posedge clk_sys_i) if (pop === 1'b1) pops++;
	logic [19:0] tbl [5] = '{20'h4ff7f, 20'h0ff7d, 20'h00000, 20'h1ff00,
		20'h40000};
	logic [7:0] fm [4] = '{8'h40, 8'h20, 8'h08, 8'h01};
	always #25 clk_sys_i = !clk_sys_i;
	usbirq_line_model line (.clk_sys_i, .act_i(act), .dp_o(dp), .dm_o(dm));
	usbirq_top #(.IDLE_CYC(IC)) uut (.clk_sys_i, .resetn_i,
		.wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we),
		.wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat),
		.wb_dat_o(rdo), .wb_ack_o(ack), .evt_err_i(evt.err),
		.evt_frame_start_i(evt.frame_start), .evt_stall_sent_i(evt.stall_sent),
		.evt_trn_done_i(evt.trn_done), .evt_bus_reset_i(evt.bus_reset),
		.dp_i(dp), .dm_i(dm), .fifo_advance_o(pop),
		.device_address_o(addr), .usb_module_irq_request_o(irq));
////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("Error %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_sys_i);
		req <= '{1'b1, 1'b1, w, a, 4'h1, {24'h0, d}};
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (ack !== 1'b1 && n < 9);
		v = rdo;
		req <= '0;
		if (ack !== 1'b1) begin
			err_count++;
			final_report();
		end
		#1;
	endtask
	task automatic pulse(input logic [11:0] e);
		@(posedge clk_sys_i);
		evt <= e;
		@(posedge clk_sys_i);
		evt <= '0;
	endtask
////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		foreach (tbl[i]) begin
			bus(1'b1, tbl[i][19:16], tbl[i][15:8]);
			bus(1'b0, tbl[i][19:16], 8'h00);
			chk("row", {24'h0, tbl[i][7:0]}, v);
		end
		$display("rows done");
		for (int i = 0; i < 4; i++) begin
			pulse({4'h8 >> i, 8'h00});
			bus(1'b0, 4'h0, 8'h00);
			chk("flag", {24'h0, fm[i]}, v);
			chk("masked", 0, irq);
			bus(1'b1, 4'h4, 8'h7f);
			chk("irq", 1, irq);
			bus(1'b1, 4'h0, 8'h00);
			chk("cleared", 0, irq);
			bus(1'b1, 4'h4, 8'h00);
		end
		$display("events done");
		pulse(12'h001);
		bus(1'b0, 4'h0, 8'h00);
		chk("summary", 0, v);
		bus(1'b1, 4'hc, 8'h01);
		bus(1'b0, 4'h0, 8'h00);
		chk("summary", 2, v);
		bus(1'b1, 4'h0, 8'h00);
		bus(1'b0, 4'h0, 8'h00);
		chk("summary", 2, v);
		bus(1'b1, 4'h8, 8'h00);
		bus(1'b0, 4'h0, 8'h00);
		chk("summary", 0, v);
		$display("errors done");
		act <= 1'b0;
		repeat (IC + 9) @(posedge clk_sys_i);
		bus(1'b0, 4'h0, 8'h00);
		chk("idle", 32'h10, v);
		bus(1'b1, 4'h0, 8'h00);
		bus(1'b1, 4'h4, 8'h04);
		act <= 1'b1;
		repeat (9) @(posedge clk_sys_i);
		chk("activity", 1, irq);
		bus(1'b1, 4'h0, 8'h00);
		repeat (9) @(posedge clk_sys_i);
		bus(1'b0, 4'h0, 8'h00);
		chk("rearm", 0, v);
		chk("pops", 2, pops);
		$display("idle done");
		resetn_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		bus(1'b0, 4'h4, 8'h00);
		chk("enables", 0, v);
		chk("addr", 0, addr);
		$display("reset done");
		final_report();
	end
endmodule // usbirq_top_tb
`default_nettype wire
